// [include/fbpc_pkg.sv]
// =====================================================================
// Shared constants for the fan bridge protection control block
`default_nettype none
package fbpc_pkg;
   // Clock rate
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned CLK_NS = 100;
   // Lock-detect window in lock-timer triangle periods
   localparam int unsigned LOCK_PERIODS = 8;
   // Retry off interval relative to the on interval
   localparam int unsigned RETRY_RATIO = 15;
   // Current-trip recirculation time
   localparam int unsigned RECIRC_US = 50;
   localparam int unsigned RECIRC_CYC = (RECIRC_US * 1000 + CLK_NS - 1) / CLK_NS;
   // Hall pulse reject interval
   localparam int unsigned REJECT_US = 2;
   localparam int unsigned REJECT_CYC = (REJECT_US * 1000 + CLK_NS - 1) / CLK_NS;
   // Dead time between complementary gates
   localparam int unsigned DEAD_NS = 1000;
   localparam int unsigned DEAD_CYC = (DEAD_NS + CLK_NS - 1) / CLK_NS;
   // Soft-start ramp step time and level width
   localparam int unsigned SS_STEP_CYC = 64;
   localparam int unsigned SS_BITS = 8;
   // APB register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
   // Control field positions and reset value
   localparam int unsigned CTRL_SS_EN = 0;
   localparam int unsigned CTRL_DRV_EN = 1;
   localparam logic [1:0] CTRL_RESET = 2'h2;
   // Interrupt bit positions and width
   localparam int unsigned IRQ_LOCK = 0;
   localparam int unsigned IRQ_TRIP = 1;
   localparam int unsigned IRQ_THERM = 2;
   localparam int unsigned IRQ_UV = 3;
   localparam int unsigned IRQ_W = 4;
endpackage : fbpc_pkg
`default_nettype wire

// [core/fbpc_top.sv]
// Functional notes
// - Watch speed output for lock stoppage
// - Lock window is eight timer periods
// - On lock: high sides off, lows on
// - Auto retry, off fifteen times on
// - Lock fault output high during fault
// - Speed output toggles at Hall threshold
// - Current trip clears high-side enable latch
// - Recirculate fixed 50 us after trip
// - Soft start ramps permitted current gradually
// - Synchronous rectification during PWM off
// - Thermal cutout disables all gate outputs
// - Low pump or supply disables outputs
// - Power-up lockout keeps drivers off
// - Supply flag with rise/fall hysteresis
// - Pump flag releases above threshold
// - Speed output is open drain
`timescale 1ns/1ps
`default_nettype none
module fbpc_top #(
   parameter int unsigned RECIRC_CYCLES = fbpc_pkg::RECIRC_CYC,
   parameter int unsigned REJECT_CYCLES = fbpc_pkg::REJECT_CYC,
   parameter int unsigned DEAD_CYCLES = fbpc_pkg::DEAD_CYC,
   parameter int unsigned SS_STEP = fbpc_pkg::SS_STEP_CYC
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic clk_en_i,
   // Analog front-end comparator levels, timer ticks and PWM input
   input wire logic hall_cmp_i,
   input wire logic lock_timer_tick_i,
   input wire logic chop_freq_tick_i,
   input wire logic pwm_on_i,
   input wire logic sense_trip_i,
   input wire logic thermal_cutout_i,
   input wire logic main_supply_ok_i,
   input wire logic pump_rail_ok_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Gate drives
   output logic gate_ha_o,
   output logic gate_la_o,
   output logic gate_hb_o,
   output logic gate_lb_o,
   // Open-drain indicators
   output logic speed_toggle_out_o,
   output logic speed_toggle_out_oe_o,
   output logic lock_fault_o,
   output logic lock_fault_oe_o,
   // Soft-start current level and interrupt
   output logic [fbpc_pkg::SS_BITS-1:0] ilim_level_o,
   output logic irq_o
);
   typedef enum logic [1:0] {FBPC_RUN, FBPC_LOCK_OFF, FBPC_RETRY_ON} fbpc_lock_e;

   logic [1:0] ctrl_reg;
   logic [fbpc_pkg::IRQ_W-1:0] irq_stat_reg, irq_mask_reg, irq_set;
   logic hall_ff_reg, hall_filt_reg, speed_reg;
   logic [15:0] rej_cnt_reg;
   logic speed_prev_reg;
   logic [3:0] lock_cnt_reg;
   logic [7:0] retry_cnt_reg;
   fbpc_lock_e lock_state_reg;
   logic lock_active;
   logic hs_en_reg;
   logic [15:0] recirc_cnt_reg;
   logic [fbpc_pkg::SS_BITS-1:0] ss_level_reg;
   logic [15:0] ss_cnt_reg;
   logic trip_prev_reg, therm_prev_reg, uv_prev_reg, lock_prev_reg;
   logic apb_wr;
   logic [31:0] prdata_next;
   logic fault_off, uv_fault;
   logic want_ha, want_la, want_hb, want_lb;
   logic [3:0] want, gate_reg;
   logic [15:0] dead_cnt_reg;
   logic speed_edge;

   // =====================================================================
   // Supply and thermal gating
   // Supply comparators already carry their analog hysteresis
   // comparator flags used
   assign uv_fault = !main_supply_ok_i || !pump_rail_ok_i;
   assign fault_off = thermal_cutout_i || uv_fault || !ctrl_reg[fbpc_pkg::CTRL_DRV_EN];

   // =====================================================================
   // Hall filtering and speed toggle
   // pulse reject filter
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         hall_ff_reg <= 1'b0;
         hall_filt_reg <= 1'b0;
         rej_cnt_reg <= 16'h0000;
      end else if (clk_en_i) begin
         hall_ff_reg <= hall_cmp_i;
         if (hall_ff_reg == hall_filt_reg) begin
            rej_cnt_reg <= 16'h0000;
         end else if (rej_cnt_reg >= 16'(REJECT_CYCLES - 1)) begin
            hall_filt_reg <= hall_ff_reg;
            rej_cnt_reg <= 16'h0000;
         end else begin
            rej_cnt_reg <= rej_cnt_reg + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         speed_reg <= 1'b0;
         speed_prev_reg <= 1'b0;
      end else if (clk_en_i) begin
         speed_reg <= hall_filt_reg;
         speed_prev_reg <= speed_reg;
      end
   end
   assign speed_edge = speed_reg != speed_prev_reg;

   // =====================================================================
   // Lock detect and retry
   // lock window and retry cadence
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         lock_state_reg <= FBPC_RUN;
         lock_cnt_reg <= 4'h0;
         retry_cnt_reg <= 8'h00;
      end else if (clk_en_i) begin
         unique case (lock_state_reg)
            FBPC_RUN, FBPC_RETRY_ON: begin
               if (speed_edge) begin
                  lock_cnt_reg <= 4'h0;
                  lock_state_reg <= FBPC_RUN;
               end else if (lock_timer_tick_i) begin
                  if (lock_cnt_reg == 4'(fbpc_pkg::LOCK_PERIODS - 1)) begin
                     lock_cnt_reg <= 4'h0;
                     retry_cnt_reg <= 8'h00;
                     lock_state_reg <= FBPC_LOCK_OFF;
                  end else begin
                     lock_cnt_reg <= lock_cnt_reg + 4'h1;
                  end
               end
            end
            FBPC_LOCK_OFF: begin
               // Off lasts fifteen lock windows, on lasts one window
               if (lock_timer_tick_i) begin
                  if (retry_cnt_reg == 8'(fbpc_pkg::LOCK_PERIODS * fbpc_pkg::RETRY_RATIO - 1)) begin
                     retry_cnt_reg <= 8'h00;
                     lock_cnt_reg <= 4'h0;
                     lock_state_reg <= FBPC_RETRY_ON;
                  end else begin
                     retry_cnt_reg <= retry_cnt_reg + 8'h01;
                  end
               end
            end
         endcase
      end
   end
   assign lock_active = lock_state_reg == FBPC_LOCK_OFF;

   // =====================================================================
   // Current trip and soft start
   // trip clears latch, fixed recirculation
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         hs_en_reg <= 1'b0;
         recirc_cnt_reg <= 16'h0000;
      end else if (clk_en_i) begin
         if (sense_trip_i && hs_en_reg) begin
            hs_en_reg <= 1'b0;
            recirc_cnt_reg <= 16'(RECIRC_CYCLES - 1);
         end else if (!hs_en_reg) begin
            if (recirc_cnt_reg == 16'h0000) begin
               hs_en_reg <= 1'b1;
            end else begin
               recirc_cnt_reg <= recirc_cnt_reg - 16'h0001;
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         ss_level_reg <= '0;
         ss_cnt_reg <= 16'h0000;
      end else if (clk_en_i) begin
         if (fault_off || lock_active) begin
            ss_level_reg <= '0;
            ss_cnt_reg <= 16'h0000;
         end else if (!ctrl_reg[fbpc_pkg::CTRL_SS_EN]) begin
            ss_level_reg <= '1;
         end else if (ss_level_reg != '1) begin
            if (ss_cnt_reg >= 16'(SS_STEP - 1)) begin
               ss_cnt_reg <= 16'h0000;
               ss_level_reg <= ss_level_reg + {{(fbpc_pkg::SS_BITS-1){1'b0}}, 1'b1};
            end else begin
               ss_cnt_reg <= ss_cnt_reg + 16'h0001;
            end
         end
      end
   end

   // =====================================================================
   // Bridge state selection
   // Speed level picks the driven diagonal; off phase decays through lows
   always_comb begin
      want_ha = 1'b0;
      want_hb = 1'b0;
      want_la = 1'b0;
      want_lb = 1'b0;
      if (fault_off) begin
         want_la = 1'b0;
      end else if (lock_active) begin
         want_la = 1'b1;
         want_lb = 1'b1;
      end else if (pwm_on_i && hs_en_reg) begin
         want_ha = speed_reg;
         want_lb = speed_reg;
         want_hb = !speed_reg;
         want_la = !speed_reg;
      end else begin
         want_la = 1'b1;
         want_lb = 1'b1;
      end
   end
   assign want = {want_ha, want_la, want_hb, want_lb};

   // dead time after any gate turns off, before a gate turns on
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         gate_reg <= 4'h0;
         dead_cnt_reg <= 16'h0000;
      end else if (clk_en_i) begin
         if (fault_off) begin
            gate_reg <= 4'h0;
            dead_cnt_reg <= 16'(DEAD_CYCLES);
         end else if (want != gate_reg) begin
            if ((gate_reg & ~want) != 4'h0) begin
               gate_reg <= gate_reg & want;
               dead_cnt_reg <= 16'(DEAD_CYCLES);
            end else if (dead_cnt_reg != 16'h0000) begin
               dead_cnt_reg <= dead_cnt_reg - 16'h0001;
            end else begin
               gate_reg <= want;
            end
         end else if (dead_cnt_reg != 16'h0000) begin
            dead_cnt_reg <= dead_cnt_reg - 16'h0001;
         end
      end
   end

   // =====================================================================
   // Registered outputs
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         gate_ha_o <= 1'b0;
         gate_la_o <= 1'b0;
         gate_hb_o <= 1'b0;
         gate_lb_o <= 1'b0;
         speed_toggle_out_o <= 1'b0;
         speed_toggle_out_oe_o <= 1'b0;
         lock_fault_o <= 1'b0;
         lock_fault_oe_o <= 1'b0;
         ilim_level_o <= '0;
         irq_o <= 1'b0;
      end else if (clk_en_i) begin
         gate_ha_o <= gate_reg[3] && !fault_off;
         gate_la_o <= gate_reg[2] && !fault_off;
         gate_hb_o <= gate_reg[1] && !fault_off;
         gate_lb_o <= gate_reg[0] && !fault_off;
         // drain pulls low when speed is low
         speed_toggle_out_o <= 1'b0;
         speed_toggle_out_oe_o <= !speed_reg;
         // released drain reads high on lock
         lock_fault_o <= 1'b0;
         lock_fault_oe_o <= !lock_active;
         ilim_level_o <= ss_level_reg;
         irq_o <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // =====================================================================
   // Interrupt events and APB registers
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         trip_prev_reg <= 1'b0;
         therm_prev_reg <= 1'b0;
         // Supply is taken as low at power-up, so reset logs no false event
         uv_prev_reg <= 1'b1;
         lock_prev_reg <= 1'b0;
      end else if (clk_en_i) begin
         trip_prev_reg <= hs_en_reg;
         therm_prev_reg <= thermal_cutout_i;
         uv_prev_reg <= uv_fault;
         lock_prev_reg <= lock_active;
      end
   end
   always_comb begin
      irq_set = '0;
      irq_set[fbpc_pkg::IRQ_LOCK] = lock_active && !lock_prev_reg;
      irq_set[fbpc_pkg::IRQ_TRIP] = trip_prev_reg && !hs_en_reg;
      irq_set[fbpc_pkg::IRQ_THERM] = thermal_cutout_i && !therm_prev_reg;
      irq_set[fbpc_pkg::IRQ_UV] = uv_fault && !uv_prev_reg;
   end

   // Writes land only at the access edge that sees pready high
   assign apb_wr = psel_i && penable_i && pwrite_i && pready_o;
   // Set wins over a write-one clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         ctrl_reg <= fbpc_pkg::CTRL_RESET;
         irq_stat_reg <= '0;
         irq_mask_reg <= '0;
      end else if (clk_en_i) begin
         if (apb_wr && paddr_i == fbpc_pkg::ADDR_IRQ_STAT) begin
            irq_stat_reg <= (irq_stat_reg & ~pwdata_i[fbpc_pkg::IRQ_W-1:0]) | irq_set;
         end else begin
            irq_stat_reg <= irq_stat_reg | irq_set;
         end
         if (apb_wr && paddr_i == fbpc_pkg::ADDR_CTRL) begin
            ctrl_reg <= pwdata_i[1:0];
         end
         if (apb_wr && paddr_i == fbpc_pkg::ADDR_IRQ_MASK) begin
            irq_mask_reg <= pwdata_i[fbpc_pkg::IRQ_W-1:0];
         end
      end
   end

   // Read word selection by address
   always_comb begin
      unique case (paddr_i)
         fbpc_pkg::ADDR_CTRL: prdata_next = {30'h0, ctrl_reg};
         fbpc_pkg::ADDR_STAT: prdata_next = {24'h0, 1'b0, lock_active, hs_en_reg, speed_reg,
                                             pump_rail_ok_i, main_supply_ok_i, thermal_cutout_i,
                                             uv_fault};
         fbpc_pkg::ADDR_IRQ_STAT: prdata_next = {28'h0, irq_stat_reg};
         fbpc_pkg::ADDR_IRQ_MASK: prdata_next = {28'h0, irq_mask_reg};
         default: prdata_next = 32'h0;
      endcase
   end

   // Bus outputs registered in the setup cycle, so the access phase needs no wait
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         prdata_o <= 32'h0;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
      end else if (clk_en_i) begin
         pslverr_o <= 1'b0;
         pready_o <= psel_i && !penable_i;
         if (psel_i && !penable_i) begin
            prdata_o <= prdata_next;
         end
      end
   end

   // =====================================================================
   // Checks
   AST_TRIP_OFF: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (clk_en_i && sense_trip_i && hs_en_reg) |=> !hs_en_reg) else $error("trip kept latch");
   AST_RECIRC: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      $fell(hs_en_reg) |-> !hs_en_reg [*8]) else $error("recirculation too short");
   AST_NO_SHOOT_A: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !(gate_ha_o && gate_la_o)) else $error("leg A shoot through");
   AST_NO_SHOOT_B: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !(gate_hb_o && gate_lb_o)) else $error("leg B shoot through");
   AST_FAULT_OFF: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (clk_en_i && thermal_cutout_i) |=> !(gate_ha_o || gate_hb_o || gate_la_o || gate_lb_o))
      else $error("gates on during thermal cutout");
   AST_UV_OFF: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (clk_en_i && uv_fault) |=> !(gate_ha_o || gate_hb_o)) else $error("gates on in uv");
   AST_LOCK_BRAKE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (clk_en_i && lock_active && !fault_off) [*3] |-> !gate_ha_o && !gate_hb_o)
      else $error("high side on during lock");
   AST_LOCK_FLAG: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (clk_en_i && lock_active) |=> !lock_fault_oe_o) else $error("lock flag not released");
endmodule : fbpc_top
`default_nettype wire

// [sim/fbpc_fan_model.sv]
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Winding, sense resistor and Hall element behind the gate drives
module fbpc_fan_model #(
   parameter int unsigned TRIP_LEVEL = 30
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Gate drives from the block
   input wire logic gate_ha_i,
   input wire logic gate_la_i,
   input wire logic gate_hb_i,
   input wire logic gate_lb_i,
   // Bench controls
   input wire logic load_en_i,
   input wire logic rotor_pos_i,
   // Sensed levels back to the block
   output logic hall_cmp_o,
   output logic sense_trip_o
);
   int unsigned current_reg;
   // Current builds only across a diagonal; it decays once a high side opens
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         current_reg <= 0;
      end else if (load_en_i && ((gate_ha_i && gate_lb_i) || (gate_hb_i && gate_la_i))) begin
         current_reg <= current_reg + 1;
      end else if (current_reg != 0) begin
         current_reg <= current_reg - 1;
      end
   end
   // Peak comparator and Hall level, no extra filtering
   assign sense_trip_o = (current_reg >= TRIP_LEVEL);
   assign hall_cmp_o = rotor_pos_i;
endmodule // fbpc_fan_model
`default_nettype wire

// [sim/fbpc_top_test.sv]
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Self-checking bench for the fan bridge protection control block
module fbpc_top_test;
   localparam int RECIRC = 20;
   localparam int DEAD = 2;
   logic clk_i, rst_b_i, hall, tick, pwm_on, therm, main_ok, pump_ok, load_en, rotor;
   logic psel, penable, pwrite, pready_o, pslverr_o, irq_o, sense;
   logic [7:0] paddr, ilim;
   logic [31:0] pwdata, prdata_o, q;
   logic ha, la, hb, lb, spd, spd_oe, lck, lck_oe;
   int err_total, check_count, n, i;
   wire logic [3:0] gates = {ha, la, hb, lb};
   fbpc_top #(.RECIRC_CYCLES(RECIRC), .REJECT_CYCLES(3), .DEAD_CYCLES(DEAD), .SS_STEP(2))
   i_fbpc_top (.clk_i(clk_i), .rst_b_i(rst_b_i), .clk_en_i(1'b1), .hall_cmp_i(hall),
      .lock_timer_tick_i(tick), .chop_freq_tick_i(1'b0), .pwm_on_i(pwm_on),
      .sense_trip_i(sense), .thermal_cutout_i(therm), .main_supply_ok_i(main_ok),
      .pump_rail_ok_i(pump_ok), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .gate_ha_o(ha), .gate_la_o(la), .gate_hb_o(hb), .gate_lb_o(lb),
      .speed_toggle_out_o(spd), .speed_toggle_out_oe_o(spd_oe), .lock_fault_o(lck),
      .lock_fault_oe_o(lck_oe), .ilim_level_o(ilim), .irq_o(irq_o));
   fbpc_fan_model i_fbpc_fan_model (.clk_i(clk_i), .rst_b_i(rst_b_i), .gate_ha_i(ha),
      .gate_la_i(la), .gate_hb_i(hb), .gate_lb_i(lb), .load_en_i(load_en),
      .rotor_pos_i(rotor), .hall_cmp_o(hall), .sense_trip_o(sense));
   // =====================================================================
   // Common tasks
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
         err_total++;
      end
   endtask
   function automatic logic pick(input int sel);
      case (sel)
         0: pick = spd_oe;
         1: pick = lck_oe;
         2: pick = ha;
         3: pick = hb;
         4: pick = la;
         5: pick = irq_o;
         6: pick = (ilim == 8'hff);
         default: pick = (gates == 4'h0);
      endcase
   endfunction
   // Bounded wait; a hang ends the run as a failure
   task automatic wait_sig(input int sel, input logic val);
      n = 0;
      while (pick(sel) !== val && n < 2000) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      if (n == 2000) begin
         err_total++;
         results();
      end
   endtask
   // One APB transfer, held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 100);
      q = prdata_o;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
      if (n == 100) begin
         err_total++;
         results();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(q, exp);
   endtask
   task automatic ticks(input int cnt);
      repeat (cnt) begin
         @(posedge clk_i);
         tick <= 1'b1;
         @(posedge clk_i);
         tick <= 1'b0;
      end
      #1;
   endtask
   // =====================================================================
   // Scenarios
   task automatic t_powerup();
      check(gates, 4'h0);
      rd(fbpc_pkg::ADDR_STAT, 32'h29);
      main_ok <= 1'b1;
      wait_sig(3, 1'b1);
      check(gates, 4'b0110);
   endtask
   task automatic t_regs();
      rd(fbpc_pkg::ADDR_CTRL, 32'h2);
      rd(fbpc_pkg::ADDR_IRQ_STAT, 32'h0);
      apb(1'b1, 8'h10, 32'hffffffff);
      rd(8'h10, 32'h0);
      apb(1'b1, fbpc_pkg::ADDR_CTRL, 32'h0);
      wait_sig(7, 1'b1);
      apb(1'b1, fbpc_pkg::ADDR_CTRL, 32'h2);
      wait_sig(3, 1'b1);
   endtask
   task automatic t_hall();
      @(posedge clk_i);
      rotor <= 1'b1;
      repeat (2) @(posedge clk_i);
      rotor <= 1'b0;
      repeat (8) @(posedge clk_i);
      #1;
      check(spd_oe, 1'b1);
      rotor <= 1'b1;
      wait_sig(3, 1'b0);
      for (i = 0; i < 50 && ha !== 1'b1; i++) @(posedge clk_i);
      #1;
      check(i >= DEAD, 1'b1);
      check({spd, spd_oe, gates}, 6'b001001);
   endtask
   task automatic t_pwm();
      pwm_on <= 1'b0;
      wait_sig(4, 1'b1);
      check(gates, 4'b0101);
      pwm_on <= 1'b1;
      wait_sig(2, 1'b1);
   endtask
   task automatic t_trip();
      apb(1'b1, fbpc_pkg::ADDR_IRQ_MASK, 32'h0);
      load_en <= 1'b1;
      wait_sig(2, 1'b0);
      for (i = 0; i < 200 && ha !== 1'b1; i++) @(posedge clk_i);
      load_en <= 1'b0;
      #1;
      check(i >= RECIRC && i <= RECIRC + DEAD + 4, 1'b1);
      rd(fbpc_pkg::ADDR_IRQ_STAT, 32'h2);
      check(irq_o, 1'b0);
      apb(1'b1, fbpc_pkg::ADDR_IRQ_MASK, 32'hf);
      wait_sig(5, 1'b1);
      apb(1'b1, fbpc_pkg::ADDR_IRQ_STAT, 32'hf);
      rd(fbpc_pkg::ADDR_IRQ_STAT, 32'h0);
      check(irq_o, 1'b0);
   endtask
   task automatic t_lock();
      ticks(7);
      check(lck_oe, 1'b1);
      ticks(1);
      wait_sig(1, 1'b0);
      wait_sig(4, 1'b1);
      check({lck, gates}, 5'b00101);
      rd(fbpc_pkg::ADDR_IRQ_STAT, 32'h1);
      ticks(119);
      check(lck_oe, 1'b0);
      ticks(1);
      wait_sig(1, 1'b1);
      rotor <= 1'b0;
      ticks(7);
      check(lck_oe, 1'b1);
      apb(1'b1, fbpc_pkg::ADDR_IRQ_STAT, 32'hf);
   endtask
   task automatic t_fault();
      for (int f = 0; f < 3; f++) begin
         therm <= (f == 0);
         main_ok <= (f != 1);
         pump_ok <= (f != 2);
         wait_sig(7, 1'b1);
         repeat (5) @(posedge clk_i);
         #1;
         check(gates, 4'h0);
         therm <= 1'b0;
         main_ok <= 1'b1;
         pump_ok <= 1'b1;
         wait_sig(7, 1'b0);
      end
      rd(fbpc_pkg::ADDR_IRQ_STAT, 32'hc);
   endtask
   task automatic t_soft();
      apb(1'b1, fbpc_pkg::ADDR_CTRL, 32'h0);
      apb(1'b1, fbpc_pkg::ADDR_CTRL, 32'h3);
      check(ilim < 8'h10, 1'b1);
      wait_sig(6, 1'b1);
   endtask
   // =====================================================================
   // Clock, reset and main sequence
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   initial begin
      {rst_b_i, tick, therm, main_ok, load_en, rotor, psel, penable, pwrite} = '0;
      {pwm_on, pump_ok} = 2'b11;
      paddr = 8'h0;
      pwdata = 32'h0;
      err_total = 0;
      check_count = 0;
      repeat (10) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      #1;
      t_powerup();
      t_regs();
      t_hall();
      t_pwm();
      t_trip();
      t_lock();
      t_fault();
      t_soft();
      results();
   end
endmodule // fbpc_top_test
`default_nettype wire
